// ### rtl/ssc_defines.svh
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// timing
`define SSC_CLK_PERIOD_NS 10
`define SSC_POR_TIME_NS 250000
`define SSC_POR_CYCLES (`SSC_POR_TIME_NS / `SSC_CLK_PERIOD_NS)

// frame edge numbers (rising serial clock edges)
`define SSC_EDGE_RW 6'h01
`define SSC_EDGE_ADDR_FIRST 6'h02
`define SSC_EDGE_ADDR_LAST 6'h07
`define SSC_EDGE_DATA_FIRST 6'h08
`define SSC_EDGE_DATA_LAST 6'h1f
`define SSC_EDGE_FRAME 6'h20
`define SSC_EDGE_CAP 6'h21

// register addresses
`define SSC_ADDR_ID 6'h00
`define SSC_ADDR_PWR 6'h01
`define SSC_ADDR_REFDIV 6'h02
`define SSC_ADDR_INTG 6'h03
`define SSC_ADDR_FRAC 6'h04
`define SSC_ADDR_SEED 6'h05
`define SSC_ADDR_MOD 6'h06

// reset values
`define SSC_PART_IDENTITY 24'h00a5c3
`define SSC_PWR_DEF 10'h001
`define SSC_REFDIV_DEF 14'h0001
`define SSC_INTG_DEF 16'h00c8
`define SSC_FRAC_DEF 24'h000000
`define SSC_SEED_DEF 24'h000000
`define SSC_MOD_DEF 2'h3

// field positions
`define SSC_SWRST_BIT 0
`define SSC_PIN_SEL_BIT 0
`define SSC_FROM_REG_BIT 1
`define SSC_KEEP_LO 2
`define SSC_KEEP_HI 8
`define SSC_DIG_IO_BIT 8
`define SSC_FE_SYNC_BIT 9
`define SSC_FRAC_RSTB_BIT 0
`define SSC_BUFF_RSTB_BIT 1
`define SSC_INTG_UPPER_LO 5

`endif

// ### rtl/ssc_pkg.sv
package ssc_pkg;
   typedef enum logic [1:0] {ssc_por, ssc_idle, ssc_frame} ssc_state_t;
endpackage

// ### rtl/ssc_sync.sv
module ssc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ### rtl/ssc_port.sv
`include "ssc_defines.svh"

// Operation
// - first rising edge, low input means write
// - first rising edge, high input means read
// - address captured on rising edges 2-7
// - 24 write data bits on edges 8-31
// - read drives 24 bits on edges 8-31
// - lock indicator restored on 32nd rising edge
// - chip disabled: writes work, readback off
// - source select cleared: register bit enables
// - per-block keep-on options during power down
// - power-on reset restores defaults after 250us
// - soft-reset strobe restores register defaults
// - divider writes take effect at once
// - integer mode when modulator resets cleared
// - flag divider mis-load on upper-bit collapse
// - source field one: pin, zero: register
// - write address zero bit 0 is reset
module ssc_port
   import ssc_pkg::*;
#(
   parameter int POR_CYCLES = `SSC_POR_CYCLES,
   parameter logic [23:0] PART_IDENTITY = `SSC_PART_IDENTITY // arbitrary
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic frame_select_in,
   input wire logic serial_clk_in,
   input wire logic serial_in_line_in,
   input wire logic chip_enable_in,
   input wire logic lock_indicator_in,
   output logic lock_or_serial_out,
   output logic lock_or_serial_oe_n_out,
   output logic [13:0] ref_div_out,
   output logic [15:0] int_div_out,
   output logic [23:0] frac_div_out,
   output logic [23:0] seed_out,
   output logic modulator_on_out,
   output logic power_down_out,
   output logic [6:0] keep_on_out,
   output logic pfd_sync_sleep_out,
   output logic divider_misload_out,
   output logic por_done_out
);
   logic sen_s, sclk_s, sdi_s, ce_s, lock_s, sclk_d, rise;
   ssc_state_t state, next_state;
   logic [31:0] por_cnt, next_por_cnt;
   logic [5:0] cnt, next_cnt, addr, next_addr, n;
   logic rw, next_rw, rd_active, next_rd_active, pin, next_pin;
   logic misload, next_misload, pd, next_pd, en;
   logic [23:0] sh, next_sh, rd_sh, next_rd_sh, rd_word;
   logic [9:0] pwr, next_pwr;
   logic [13:0] refdiv, next_refdiv;
   logic [15:0] intg, next_intg;
   logic [23:0] frac, next_frac, seed, next_seed;
   logic [1:0] modc, next_modc;

   ssc_sync #(.WIDTH(5)) u_sync (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .async_in({frame_select_in, serial_clk_in, serial_in_line_in,
         chip_enable_in, lock_indicator_in}),
      .sync_out({sen_s, sclk_s, sdi_s, ce_s, lock_s})
   );

   assign rise = sclk_s & ~sclk_d;
   assign n = cnt + 6'h01;
   // enable source: pin or register bit
   assign en = pwr[`SSC_PIN_SEL_BIT] ? ce_s : pwr[`SSC_FROM_REG_BIT];

   always_comb
   begin
      case ({addr[4:0], sdi_s})
         `SSC_ADDR_ID: rd_word = PART_IDENTITY;
         `SSC_ADDR_PWR: rd_word = {14'h0000, pwr};
         `SSC_ADDR_REFDIV: rd_word = {10'h000, refdiv};
         `SSC_ADDR_INTG: rd_word = {8'h00, intg};
         `SSC_ADDR_FRAC: rd_word = frac;
         `SSC_ADDR_SEED: rd_word = seed;
         `SSC_ADDR_MOD: rd_word = {22'h000000, modc};
         default: rd_word = 24'h000000;
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_por_cnt = por_cnt;
      next_cnt = cnt;
      next_addr = addr;
      next_rw = rw;
      next_sh = sh;
      next_rd_sh = rd_sh;
      next_rd_active = rd_active & en;
      next_misload = 1'b0;
      next_pwr = pwr;
      next_refdiv = refdiv;
      next_intg = intg;
      next_frac = frac;
      next_seed = seed;
      next_modc = modc;
      next_pin = pin;
      case (state)
         ssc_por:
         begin
            if (por_cnt >= 32'(POR_CYCLES - 1))
               next_state = ssc_idle;
            else
               next_por_cnt = por_cnt + 32'h1;
         end
         ssc_idle, ssc_frame:
         begin
            if (!sen_s)
            begin
               // commit only complete write frames
               if (state == ssc_frame && cnt == `SSC_EDGE_FRAME && !rw)
               begin
                  case (addr)
                     `SSC_ADDR_ID:
                     begin
                        if (sh[`SSC_SWRST_BIT])
                        begin
                           next_pwr = `SSC_PWR_DEF;
                           next_refdiv = `SSC_REFDIV_DEF;
                           next_intg = `SSC_INTG_DEF;
                           next_frac = `SSC_FRAC_DEF;
                           next_seed = `SSC_SEED_DEF;
                           next_modc = `SSC_MOD_DEF;
                        end
                     end
                     `SSC_ADDR_PWR: next_pwr = sh[9:0];
                     `SSC_ADDR_REFDIV: next_refdiv = sh[13:0];
                     `SSC_ADDR_INTG:
                     begin
                        next_intg = sh[15:0];
                        next_misload = (intg[15:5] & sh[15:5]) == 11'h000;
                     end
                     `SSC_ADDR_FRAC: next_frac = sh;
                     `SSC_ADDR_SEED: next_seed = sh;
                     `SSC_ADDR_MOD: next_modc = sh[1:0];
                     default: next_modc = modc;
                  endcase
               end
               next_state = ssc_idle;
               next_cnt = 6'h00;
               next_rd_active = 1'b0;
            end
            else
            begin
               next_state = ssc_frame;
               if (rise && cnt != `SSC_EDGE_CAP)
               begin
                  next_cnt = n;
                  if (n == `SSC_EDGE_RW)
                     next_rw = sdi_s;
                  if (n >= `SSC_EDGE_ADDR_FIRST && n <= `SSC_EDGE_ADDR_LAST)
                     next_addr = {addr[4:0], sdi_s};
                  if (n == `SSC_EDGE_ADDR_LAST)
                     next_rd_sh = rd_word;
                  if (n >= `SSC_EDGE_DATA_FIRST && n <= `SSC_EDGE_DATA_LAST)
                  begin
                     if (!rw)
                        next_sh = {sh[22:0], sdi_s};
                     else
                     begin
                        next_rd_active = en;
                        next_pin = rd_sh[23];
                        next_rd_sh = {rd_sh[22:0], 1'b0};
                     end
                  end
                  if (n == `SSC_EDGE_FRAME)
                     next_rd_active = 1'b0;
               end
            end
         end
         default: next_state = ssc_idle;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         state <= ssc_por;
         por_cnt <= 32'h0;
         sclk_d <= 1'b0;
         cnt <= 6'h00;
         addr <= 6'h00;
         rw <= 1'b0;
         sh <= 24'h000000;
         rd_sh <= 24'h000000;
         rd_active <= 1'b0;
         pin <= 1'b0;
         misload <= 1'b0;
         pd <= 1'b0;
         pwr <= `SSC_PWR_DEF;
         refdiv <= `SSC_REFDIV_DEF;
         intg <= `SSC_INTG_DEF;
         frac <= `SSC_FRAC_DEF;
         seed <= `SSC_SEED_DEF;
         modc <= `SSC_MOD_DEF;
      end
      else
      begin
         state <= next_state;
         por_cnt <= next_por_cnt;
         sclk_d <= sclk_s;
         cnt <= next_cnt;
         addr <= next_addr;
         rw <= next_rw;
         sh <= next_sh;
         rd_sh <= next_rd_sh;
         rd_active <= next_rd_active;
         pin <= next_pin;
         misload <= next_misload;
         pd <= ~en;
         pwr <= next_pwr;
         refdiv <= next_refdiv;
         intg <= next_intg;
         frac <= next_frac;
         seed <= next_seed;
         modc <= next_modc;
      end
   end

   // shared pin: read data or lock indicator
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         lock_or_serial_out <= 1'b0;
      else
         lock_or_serial_out <= next_rd_active ? next_pin : lock_s;
   end

   assign lock_or_serial_oe_n_out = pd & ~pwr[`SSC_DIG_IO_BIT];
   assign ref_div_out = refdiv;
   assign int_div_out = intg;
   assign frac_div_out = frac;
   assign seed_out = seed;
   assign modulator_on_out = modc[`SSC_FRAC_RSTB_BIT] &
      modc[`SSC_BUFF_RSTB_BIT];
   assign power_down_out = pd;
   assign keep_on_out = pwr[`SSC_KEEP_HI:`SSC_KEEP_LO];
   assign pfd_sync_sleep_out = pwr[`SSC_FE_SYNC_BIT];
   assign divider_misload_out = misload;
   assign por_done_out = (state != ssc_por);

   property p_rw_flag;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state != ssc_por && sen_s && rise && cnt == 6'h00)
         |=> (rw == $past(sdi_s));
   endproperty
   a_rw_flag: assert property (p_rw_flag)
      else $error("read/write flag not captured");

   property p_addr_bit;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_frame && sen_s && rise && cnt == 6'h06)
         |=> (addr[0] == $past(sdi_s)) && (addr[5:1] == $past(addr[4:0]));
   endproperty
   a_addr_bit: assert property (p_addr_bit)
      else $error("address bit not captured");

   property p_intg_write;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_frame && !sen_s && cnt == 6'h20 && !rw && addr == 6'h03)
         |=> (int_div_out == $past(sh[15:0]));
   endproperty
   a_intg_write: assert property (p_intg_write)
      else $error("integer divider not updated at once");

   property p_short_frame;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_frame && !sen_s && cnt != 6'h20)
         |=> $stable(int_div_out) && $stable(frac_div_out) && $stable(pwr);
   endproperty
   a_short_frame: assert property (p_short_frame)
      else $error("partial frame altered a register");

   property p_read_start;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_frame && sen_s && rise && cnt == 6'h07 && rw && en)
         |=> rd_active ##1 (lock_or_serial_out == $past(pin));
   endproperty
   a_read_start: assert property (p_read_start)
      else $error("read data not driven from edge eight");

   property p_lock_back;
      @(posedge clk_sys_in) disable iff (srst_in)
      (sen_s && rise && cnt == 6'h1f) |=> !rd_active ##1
         (lock_or_serial_out == $past(lock_s));
   endproperty
   a_lock_back: assert property (p_lock_back)
      else $error("lock indicator not restored");

   property p_pd_read;
      @(posedge clk_sys_in) disable iff (srst_in)
      !en |=> !rd_active;
   endproperty
   a_pd_read: assert property (p_pd_read)
      else $error("read active while disabled");

   property p_reg_enable;
      @(posedge clk_sys_in) disable iff (srst_in)
      (!pwr[0] && $stable(pwr)) |=> (power_down_out == !$past(pwr[1]));
   endproperty
   a_reg_enable: assert property (p_reg_enable)
      else $error("register enable not followed");

   property p_soft_reset;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_frame && !sen_s && cnt == 6'h20 && !rw
         && addr == 6'h00 && sh[0])
         |=> (int_div_out == 16'h00c8) && (pwr == 10'h001);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset did not restore defaults");

   property p_misload;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_frame && !sen_s && cnt == 6'h20 && !rw && addr == 6'h03)
         |=> (divider_misload_out ==
            (($past(intg[15:5]) & $past(sh[15:5])) == 11'h000));
   endproperty
   a_misload: assert property (p_misload)
      else $error("mis-load flag wrong");

   property p_por_end;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == ssc_por && por_cnt >= 32'(POR_CYCLES - 1))
         |=> por_done_out && (int_div_out == 16'h00c8);
   endproperty
   a_por_end: assert property (p_por_end)
      else $error("power-on reset did not finish");
endmodule

// ### test/ssc_host_model.sv
module ssc_host_model (
   input wire logic clk_sys_in,
   input wire logic pin_in,
   output logic frame_select_out,
   output logic serial_clk_out,
   output logic serial_in_line_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      frame_select_out = 1'b0;
      serial_clk_out = 1'b0;
      serial_in_line_out = 1'b0;
   end

   // one frame, serial clock still outside it
   task automatic frame(input logic rw, input logic [5:0] addr,
                        input logic [23:0] data, input int rises,
                        output logic [23:0] rdata);
      logic [30:0] bits;
      bits = {rw, addr, data};
      rdata = 24'h0;
      @(posedge clk_sys_in);
      frame_select_out <= 1'b1;
      serial_in_line_out <= bits[30];
      repeat (7) @(posedge clk_sys_in);
      for (int i = 1; i <= rises; i++)
      begin
         @(posedge clk_sys_in);
         serial_clk_out <= 1'b1;
         repeat (7) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         if (i >= 8 && i <= 31)
            rdata = {rdata[22:0], pin_in};
         @(posedge clk_sys_in);
         serial_clk_out <= 1'b0;
         if (i < 31)
            serial_in_line_out <= bits[30-i];
         if (i == rises)
            frame_select_out <= 1'b0;
         repeat (7) @(posedge clk_sys_in);
      end
      @(posedge clk_sys_in);
      serial_in_line_out <= ~serial_in_line_out;
      repeat (7) @(posedge clk_sys_in);
   endtask
endmodule

// ### test/synth_serial_ctrl_port_tb_top.sv
module synth_serial_ctrl_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // arbitrary identity value
   localparam logic [23:0] ID = 24'h3c5a96;

   logic clk_sys_in, srst_in, chip_en, lock;
   logic sel, sclk, serial_in_line, pin, oe_n, mod_on, pd, sleep, misload, por_done;
   logic [13:0] ref_div;
   logic [15:0] int_div;
   logic [23:0] frac_div, seed, rdata;
   logic [6:0] keep_on;
   int fails = 0;
   int comparisons = 0;
   int misloads = 0;
   int m;

   ssc_port #(.POR_CYCLES(20), .PART_IDENTITY(ID)) i_ssc_port (
      .clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .frame_select_in(sel), .serial_clk_in(sclk),
      .serial_in_line_in(serial_in_line), .chip_enable_in(chip_en),
      .lock_indicator_in(lock), .lock_or_serial_out(pin),
      .lock_or_serial_oe_n_out(oe_n), .ref_div_out(ref_div),
      .int_div_out(int_div), .frac_div_out(frac_div), .seed_out(seed),
      .modulator_on_out(mod_on), .power_down_out(pd),
      .keep_on_out(keep_on), .pfd_sync_sleep_out(sleep),
      .divider_misload_out(misload), .por_done_out(por_done));

   ssc_host_model i_ssc_host_model (
      // released pin reads inverted
      .clk_sys_in(clk_sys_in), .pin_in(oe_n ? ~pin : pin),
      .frame_select_out(sel),
      .serial_clk_out(sclk), .serial_in_line_out(serial_in_line));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in)
      if (misload === 1'b1)
         misloads++;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      logic [23:0] unused;
      i_ssc_host_model.frame(1'b0, a, d, 32, unused);
      repeat (4) @(posedge clk_sys_in);
   endtask

   task automatic rd(input logic [5:0] a, output logic [23:0] d);
      i_ssc_host_model.frame(1'b1, a, 24'h0, 32, d);
   endtask

   task automatic defaults();
      check(24'(int_div), 24'h0000c8);
      check(24'(ref_div), 24'h000001);
      check(frac_div, 24'h0);
      check(seed, 24'h0);
      check(24'(keep_on), 24'h0);
      check(24'(mod_on), 24'h1);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk_sys_in);
      fails++;
      tally_and_finish();
   end

   initial
   begin
      logic [15:0] steps [3];
      logic [23:0] hits [3];
      steps = '{16'h0400, 16'h04c8, 16'h00c8};
      hits = '{24'h1, 24'h0, 24'h0};
      srst_in = 1'b1;
      chip_en = 1'b1;
      lock = 1'b1;
      repeat (10) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      for (int n = 0; n < 100 && por_done !== 1'b1; n++)
         @(posedge clk_sys_in);
      check(24'(por_done), 24'h1);
      defaults();
      check(24'(pd), 24'h0);
      rd(6'h00, rdata);
      check(rdata, ID);
      check(24'(pin), 24'h1);
      lock <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      check(24'(pin), 24'h0);
      lock <= 1'b1;
      check(24'(oe_n), 24'h0);
      for (int i = 0; i < 3; i++)
      begin
         m = misloads;
         wr(6'h03, 24'(steps[i]));
         check(24'(int_div), 24'(steps[i]));
         check(24'(misloads - m), hits[i]);
      end
      m = misloads;
      wr(6'h05, 24'h0);
      wr(6'h04, 24'h0);
      wr(6'h03, 24'h0cc8);
      wr(6'h03, 24'h0c00);
      wr(6'h05, 24'h50894c);
      wr(6'h04, 24'h123456);
      check(24'(misloads - m), 24'h0);
      check(seed, 24'h50894c);
      check(frac_div, 24'h123456);
      rd(6'h04, rdata);
      check(rdata, 24'h123456);
      wr(6'h06, 24'h0);
      check(24'(mod_on), 24'h0);
      wr(6'h06, 24'h3);
      check(24'(mod_on), 24'h1);
      chip_en <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      check(24'(pd), 24'h1);
      check(24'(oe_n), 24'h1);
      wr(6'h02, 24'h000007);
      check(24'(ref_div), 24'h000007);
      rd(6'h02, rdata);
      check(24'(oe_n), 24'h1);
      check(rdata, 24'h000000);
      chip_en <= 1'b1;
      wr(6'h01, 24'h0001fc);
      check(24'(pd), 24'h1);
      check(24'(keep_on), 24'h7f);
      check(24'(oe_n), 24'h0);
      wr(6'h01, 24'h000202);
      check(24'(pd), 24'h0);
      check(24'(sleep), 24'h1);
      i_ssc_host_model.frame(1'b0, 6'h02, 24'h000033, 20, rdata);
      i_ssc_host_model.frame(1'b0, 6'h02, 24'h000033, 33, rdata);
      repeat (4) @(posedge clk_sys_in);
      check(24'(ref_div), 24'h000007);
      wr(6'h00, 24'h000001);
      defaults();
      check(24'(sleep), 24'h0);
      tally_and_finish();
   end
endmodule
